// ===== verilog/tdfa_pkg.sv
// Purpose: Constants and types for the tributary demap and frame align sink
// Assumes: 40 MHz core clock, 2 048 kbit/s tributary, 8 448 kbit/s multiplex
// Notes:   All offsets, control field positions, control register reset values and counts live here
`default_nettype none
package tdfa_pkg;
    // Clock rates and derived smoothing oscillator step
    localparam int          CLK_HZ      = 40_000_000;
    localparam int          TRIB_HZ     = 2_048_000;
    localparam int          TRIB_PPM    = 50;
    localparam logic [31:0] NCO_INC     =
        32'((64'(TRIB_HZ) << 32) / 64'(CLK_HZ));
    localparam int          FILL_SHIFT  = 12;
    // Elastic store geometry, pointers one bit wider than the index
    localparam int          STORE_DEPTH = 32;
    localparam logic [5:0]  STORE_FULL  = 6'h20;
    localparam logic [5:0]  STORE_MID   = 6'h10;
    localparam logic [31:0] NCO_BASE    =
        NCO_INC - (32'(STORE_MID) << FILL_SHIFT);
    // Recovery time target after a frequency step
    localparam int          RECOVER_MS  = 1000;
    // Multiplex frame: four sets of 212 bits, bit interleaved tributaries
    localparam logic [7:0]  SET_LAST    = 8'hd3;
    localparam logic [7:0]  OVH_BITS    = 8'h0c;
    localparam logic [7:0]  CTL_BITS    = 8'h04;
    localparam logic [7:0]  JST_END     = 8'h08;
    localparam logic [1:0]  SET_JUST    = 2'h3;
    // Tributary frame words and positions within a 512 bit double frame
    localparam logic [6:0]  FAS_WORD    = 7'h1b;
    localparam logic [5:0]  MFAS_WORD   = 6'h0b;
    localparam logic [8:0]  POS_FAS_END = 9'h007;
    localparam logic [8:0]  POS_ODD_SI  = 9'h100;
    localparam logic [8:0]  POS_ODD_B2  = 9'h101;
    localparam logic [3:0]  MF_MFAS_END = 4'hb;
    localparam logic [1:0]  FAS_ERR_MAX = 2'h3;
    // Multiframe search window in double frames
    localparam int          DFRAME_US   = 250;
    localparam int          MF_SRCH_US  = 8000;
    localparam logic [5:0]  MF_SRCH_DF  = 6'(MF_SRCH_US / DFRAME_US);
    // All-ones detector: X zeros, Y bit window, Z windows
    localparam logic [1:0]  AIS_X       = 2'h2;
    localparam logic [8:0]  AIS_Y_LAST  = 9'h1ff;
    localparam logic [1:0]  AIS_Z       = 2'h3;
    localparam int          AIS_MAX_US  = 250;
    // Register map and fields
    localparam logic [7:0]  ADDR_CTRL   = 8'h00;
    localparam logic [7:0]  ADDR_STATUS = 8'h04;
    localparam int          CTRL_ACT    = 0;
    localparam int          CTRL_AISREP = 1;
    localparam int          CTRL_MODE   = 2;
    localparam logic        ACT_RST     = 1'b1;
    localparam logic        AISREP_RST  = 1'b0;
    // Checksum multiframe setting codes, the fourth code acts as off
    localparam logic [1:0]  MODE_OFF    = 2'h0;
    localparam logic [1:0]  MODE_ON     = 2'h1;
    localparam logic [1:0]  MODE_AUTO   = 2'h2;
    // Alignment states
    typedef enum logic [2:0] {
        ST_OOF   = 3'b000,
        ST_BFA   = 3'b001,
        ST_MSRCH = 3'b010,
        ST_C2C   = 3'b011,
        ST_C2N   = 3'b100
    } tdfa_state_t;
endpackage
`default_nettype wire

// ===== verilog/tdfa_sink.sv
// Purpose: Extract one 2 048 kbit/s tributary from the multiplex payload,
//          smooth it, align its frames and flag defects
// Assumes: Payload clock, data, frame start and trail fail come from
//          another clock domain; registers over APB
// Notes:   Overview of operation
// Overview of operation
// - Majority of three control bits decides if the opportunity bit is data.
// - Every recovered data bit is written into the elastic store unless the store is full.
// - Store is read by an evenly spaced clock steered by store fill.
// - Store depth covers 50 ppm offset plus permitted jitter.
// - Fill steering recovers from a frequency step well inside a second.
// - Exactly one of four tributary slots is demapped, chosen by SLOT.
// - Inactive block sends all ones and raises none of the three management reports; raw defect, multiframe present and fill bits stay readable.
// - Double frame and multiframe phase are tracked; start pulses emitted.
// - Checksum multiframe setting selects off, manual on or automatic.
// - Multiframe present stays false while the setting is off.
// - Setting on: multiframe present true only once multiframe is found.
// - Setting auto: multiframe present true only in checksum both ends.
// - Frame loss per frame search; auto mode reports no-checksum partner.
// - All-ones defect: under two zeros in three windows of 512 bits.
// - Either defect raises server fail and forces all ones immediately.
// - Normal data resumes with the next recovered bit after the all-ones action clears.
// - All-ones report needs defect, no trail fail and report enable.
// - Smoothed clock is driven out as the tributary timing reference.
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tdfa_sink
    import tdfa_pkg::*;
#(
    parameter int unsigned SLOT = 1
) (
    // Clock and reset
    input  wire logic       REF_CLK,
    input  wire logic       NRST,
    // Multiplex payload from the demapper
    input  wire logic       MULTIPLEX_PAYLOAD_DATA_IN,
    input  wire logic       MULTIPLEX_PAYLOAD_CLOCK_IN,
    input  wire logic       MULTIPLEX_FRAME_START_IN,
    input  wire logic       INCOMING_TRAIL_FAIL,
    // Tributary towards trail termination
    output logic            TRIBUTARY_DATA_OUT,
    output logic            TRIBUTARY_CLOCK_OUT,
    output logic            TRIBUTARY_SERVER_FAIL_OUT,
    output logic            TRIBUTARY_FRAME_START_OUT,
    output logic            TRIBUTARY_MULTIFRAME_START_OUT,
    output logic            MULTIFRAME_PRESENT_OUT,
    // APB slave
    input  wire logic       PSEL,
    input  wire logic       PENABLE,
    input  wire logic       PWRITE,
    input  wire logic [7:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]     PRDATA,
    output logic            PREADY,
    output logic            PSLVERR
);
    localparam logic [1:0] SLOT_IDX = 2'(SLOT - 1);

    typedef struct packed {
        logic [3:0]  pin_m;
        logic [3:0]  pin_s;
        logic [3:0]  pin_d;
        logic [1:0]  set;
        logic [7:0]  q;
        logic [2:0]  cbits;
        logic [31:0] store;
        logic [5:0]  wp;
        logic [5:0]  rp;
        logic [31:0] acc;
        logic [6:0]  sr;
        logic [5:0]  mfsr;
        logic [8:0]  pos;
        logic [3:0]  mf;
        tdfa_state_t st;
        logic        cand;
        logic        mfcand;
        logic [1:0]  ferr;
        logic [5:0]  srch;
        logic [8:0]  win;
        logic [1:0]  zc;
        logic [1:0]  lowc;
        logic [1:0]  highc;
        logic        all_ones_defect;
        logic        active;
        logic        aisrep;
        logic [1:0]  mode;
        logic        dout;
        logic        ssf;
        logic        fs_o;
        logic        mfs_o;
        logic        mfp_o;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } tdfa_regs_t;

    tdfa_regs_t  r;
    tdfa_regs_t  n;
    logic        pedge;
    logic [1:0]  cs;
    logic [7:0]  cq;
    logic        is_slot;
    logic        c_bit;
    logic        j_bit;
    logic        stuff;
    logic        wr;
    logic [5:0]  fill;
    logic [32:0] sum;
    logic        tick;
    logic        rb;
    logic [8:0]  pos;
    logic [6:0]  srn;
    logic [5:0]  mfsn;
    logic [3:0]  mf_new;
    logic        si_ev;
    logic        aligned;
    logic        mode_off;
    logic        frame_loss_defect;
    logic        all_ones_insert_action;
    logic        all_ones_report;
    logic        frame_loss_report;
    logic        no_checksum_interworking_status;
    logic [1:0]  zn;
    logic [31:0] rdata;

    // Next state of the whole block
    always_comb begin
        n        = r;
        pedge    = 1'b0;
        cs       = 2'h0;
        cq       = 8'h00;
        is_slot  = 1'b0;
        c_bit    = 1'b0;
        j_bit    = 1'b0;
        stuff    = 1'b0;
        wr       = 1'b0;
        fill     = 6'h00;
        sum      = 33'h0;
        tick     = 1'b0;
        rb       = 1'b1;
        pos      = 9'h000;
        srn      = 7'h00;
        mfsn     = 6'h00;
        mf_new   = 4'h0;
        si_ev    = 1'b0;
        zn       = 2'h0;
        rdata    = 32'h0;
        mode_off = (r.mode != MODE_ON) && (r.mode != MODE_AUTO);
        aligned  = (r.st != ST_OOF);
        frame_loss_defect = (r.st == ST_OOF);

        // Two stage synchroniser, edge found on the second stage
        n.pin_m = {INCOMING_TRAIL_FAIL, MULTIPLEX_FRAME_START_IN,
                   MULTIPLEX_PAYLOAD_DATA_IN, MULTIPLEX_PAYLOAD_CLOCK_IN};
        n.pin_s = r.pin_m;
        n.pin_d = r.pin_s;
        pedge   = r.pin_s[0] & ~r.pin_d[0];

        // Bit position in the multiplex frame
        if (pedge) begin
            if (r.pin_s[2]) begin
                n.set = 2'h0;
                n.q   = 8'h00;
            end else if (r.q == SET_LAST) begin
                n.set = r.set + 2'h1;
                n.q   = 8'h00;
            end else begin
                n.q = r.q + 8'h01;
            end
        end

        // Slot bit classification
        cs      = n.set;
        cq      = n.q;
        is_slot = (cq[1:0] == SLOT_IDX);
        c_bit   = pedge && is_slot && (cs != 2'h0) && (cq < CTL_BITS);
        j_bit   = pedge && is_slot && (cs == SET_JUST) &&
                  (cq >= CTL_BITS) && (cq < JST_END);
        stuff   = (r.cbits[0] & r.cbits[1]) | (r.cbits[0] & r.cbits[2]) |
                  (r.cbits[1] & r.cbits[2]);
        wr      = pedge && is_slot && !((cs == 2'h0) && (cq < OVH_BITS)) &&
                  !c_bit && !(j_bit && stuff);
        if (c_bit) begin
            n.cbits[cs - 2'h1] = r.pin_s[1];
        end

        // Elastic store write on the gapped clock
        fill = r.wp - r.rp;
        if (wr && (fill != STORE_FULL)) begin
            n.store[r.wp[4:0]] = r.pin_s[1];
            n.wp = r.wp + 6'h01;
        end

        // Fill steered oscillator reads the store evenly
        sum  = {1'b0, r.acc} +
               {1'b0, NCO_BASE + ({26'h0, fill} << FILL_SHIFT)};
        n.acc = sum[31:0];
        tick  = sum[32];
        if (tick && (fill != 6'h00)) begin
            rb   = r.store[r.rp[4:0]];
            n.rp = r.rp + 6'h01;
        end

        // Frame and multiframe alignment on each recovered bit
        n.fs_o  = 1'b0;
        n.mfs_o = 1'b0;
        pos     = r.pos + 9'h001;
        srn     = {r.sr[5:0], rb};
        si_ev   = tick && (pos == POS_ODD_SI);
        mfsn    = {r.mfsr[4:0], rb};
        mf_new  = r.mf + 4'h1;
        if (tick) begin
            n.sr  = srn;
            n.pos = pos;
            if ((pos == 9'h000) || (pos == POS_ODD_SI)) begin
                n.mf = mf_new;
            end
            if (si_ev) begin
                n.mfsr = mfsn;
            end
            n.fs_o  = aligned && (pos == 9'h000);
            n.mfs_o = (r.st == ST_C2C) && (pos == 9'h000) &&
                      (mf_new == 4'h0);
            unique case (r.st)
                ST_OOF: begin
                    if (!r.cand) begin
                        if (srn == FAS_WORD) begin
                            n.pos  = POS_FAS_END;
                            n.mf   = 4'h0;
                            n.cand = 1'b1;
                        end
                    end else if ((pos == POS_ODD_B2) && !rb) begin
                        n.cand = 1'b0;
                    end else if (pos == POS_FAS_END) begin
                        n.cand = 1'b0;
                        n.ferr = 2'h0;
                        if (srn == FAS_WORD) begin
                            n.st = ST_BFA;
                        end
                    end
                end
                ST_BFA: begin
                    if (!mode_off) begin
                        n.st     = ST_MSRCH;
                        n.srch   = 6'h00;
                        n.mfcand = 1'b0;
                    end
                end
                ST_MSRCH: begin
                    if (mode_off) begin
                        n.st = ST_BFA;
                    end else if (si_ev && (mfsn == MFAS_WORD)) begin
                        if (r.mfcand && (mf_new == MF_MFAS_END)) begin
                            n.st = ST_C2C;
                        end else begin
                            n.mfcand = 1'b1;
                            n.mf     = MF_MFAS_END;
                        end
                    end else if (si_ev && (mf_new == MF_MFAS_END)) begin
                        n.mfcand = 1'b0;
                    end
                    if (!mode_off && (pos == 9'h000)) begin
                        n.srch = r.srch + 6'h01;
                        if (r.srch == MF_SRCH_DF - 6'h01) begin
                            n.srch = 6'h00;
                            if (r.mode == MODE_AUTO) begin
                                n.st = ST_C2N;
                            end
                        end
                    end
                end
                ST_C2C: begin
                    if (mode_off) begin
                        n.st = ST_BFA;
                    end else if (si_ev && (mf_new == MF_MFAS_END) &&
                                 (mfsn != MFAS_WORD)) begin
                        n.st     = ST_MSRCH;
                        n.srch   = 6'h00;
                        n.mfcand = 1'b0;
                    end
                end
                ST_C2N: begin
                    if (r.mode != MODE_AUTO) begin
                        n.st = ST_BFA;
                    end
                end
                default: begin
                    n.st   = ST_OOF;
                    n.cand = 1'b0;
                end
            endcase
            // Three errored frame words in a row lose the frame
            if (aligned && (pos == POS_FAS_END)) begin
                if (srn == FAS_WORD) begin
                    n.ferr = 2'h0;
                end else if (r.ferr == FAS_ERR_MAX - 2'h1) begin
                    n.st   = ST_OOF;
                    n.cand = 1'b0;
                    n.ferr = 2'h0;
                end else begin
                    n.ferr = r.ferr + 2'h1;
                end
            end
        end
        n.mfp_o = (r.st == ST_C2C) && !mode_off;
        // Zero density detector on the recovered stream
        zn = r.zc;
        if (!rb && (r.zc != AIS_X)) begin
            zn = r.zc + 2'h1;
        end
        if (tick) begin
            n.win = r.win + 9'h001;
            n.zc  = zn;
            if (r.win == AIS_Y_LAST) begin
                n.zc = 2'h0;
                if (zn != AIS_X) begin
                    n.highc = 2'h0;
                    n.lowc  = (r.lowc == AIS_Z) ? r.lowc : r.lowc + 2'h1;
                    if (r.lowc >= AIS_Z - 2'h1) begin
                        n.all_ones_defect = 1'b1;
                    end
                end else begin
                    n.lowc  = 2'h0;
                    n.highc = (r.highc == AIS_Z) ? r.highc : r.highc + 2'h1;
                    if (r.highc >= AIS_Z - 2'h1) begin
                        n.all_ones_defect = 1'b0;
                    end
                end
            end
        end
        // Consequent actions and output data
        all_ones_insert_action = r.all_ones_defect | frame_loss_defect;
        n.ssf = all_ones_insert_action;
        if (!r.active || all_ones_insert_action) begin
            n.dout = 1'b1;
        end else if (tick) begin
            n.dout = rb;
        end
        // Management reports, silent while inactive
        all_ones_report = r.all_ones_defect & ~r.pin_s[3] & r.aisrep &
                          r.active;
        frame_loss_report = frame_loss_defect & ~r.all_ones_defect &
                            ~r.pin_s[3] & r.active;
        no_checksum_interworking_status = (r.st == ST_C2N) &&
                                          r.active;
        // APB slave: answer one cycle after setup
        if (PADDR == ADDR_CTRL) begin
            rdata = {28'h0, r.mode, r.aisrep, r.active};
        end else if (PADDR == ADDR_STATUS) begin
            rdata = {18'h0, fill, 2'h0, r.all_ones_defect,
                     frame_loss_defect, r.mfp_o,
                     no_checksum_interworking_status,
                     all_ones_report, frame_loss_report};
        end
        n.pready  = 1'b0;
        n.pslverr = 1'b0;
        if (PSEL && !PENABLE && !r.pready) begin
            n.pready  = 1'b1;
            n.prdata  = PWRITE ? 32'h0 : rdata;
            n.pslverr = (PADDR != ADDR_CTRL) && (PADDR != ADDR_STATUS);
        end
        if (PSEL && PENABLE && r.pready && PWRITE &&
            (PADDR == ADDR_CTRL)) begin
            n.active = PWDATA[CTRL_ACT];
            n.aisrep = PWDATA[CTRL_AISREP];
            n.mode   = PWDATA[CTRL_MODE +: 2];
        end
    end

    // State register with synchronous reset
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            r        <= '0;
            r.st     <= ST_OOF;
            r.active <= ACT_RST;
            r.aisrep <= AISREP_RST;
            r.mode   <= MODE_OFF;
            r.dout   <= 1'b1;
            r.ssf    <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // Outputs straight from the state register
    assign TRIBUTARY_DATA_OUT             = r.dout;
    assign TRIBUTARY_CLOCK_OUT            = r.acc[31];
    assign TRIBUTARY_SERVER_FAIL_OUT      = r.ssf;
    assign TRIBUTARY_FRAME_START_OUT      = r.fs_o;
    assign TRIBUTARY_MULTIFRAME_START_OUT = r.mfs_o;
    assign MULTIFRAME_PRESENT_OUT         = r.mfp_o;
    assign PRDATA                         = r.prdata;
    assign PREADY                         = r.pready;
    assign PSLVERR                        = r.pslverr;
endmodule // tdfa_sink
`default_nettype wire

// ===== test/tdfa_sink_props.sv
// Purpose: Port level checker for the tributary demap sink
// Assumes: Control register image is tracked from APB writes
// Notes:   Reports and all-ones paths are judged a few cycles after changes
`timescale 1ns/1ps
`default_nettype none
module tdfa_sink_props
    import tdfa_pkg::*;
(
    // Clock and reset
    input wire logic        REF_CLK,
    input wire logic        NRST,
    // Tributary side
    input wire logic        TRIBUTARY_DATA_OUT,
    input wire logic        TRIBUTARY_CLOCK_OUT,
    input wire logic        TRIBUTARY_SERVER_FAIL_OUT,
    input wire logic        TRIBUTARY_FRAME_START_OUT,
    input wire logic        TRIBUTARY_MULTIFRAME_START_OUT,
    input wire logic        MULTIFRAME_PRESENT_OUT,
    // APB
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    logic       act;
    logic [1:0] mode;
    logic       off;
    logic       rd_st;
    // Control image follows accepted writes
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            act  <= ACT_RST;
            mode <= MODE_OFF;
        end else if (PSEL && PENABLE && PREADY && PWRITE &&
                     PADDR == ADDR_CTRL) begin
            act  <= PWDATA[CTRL_ACT];
            mode <= PWDATA[CTRL_MODE+1:CTRL_MODE];
        end
    end
    assign off   = (mode != MODE_ON) && (mode != MODE_AUTO);
    assign rd_st = PSEL && PENABLE && PREADY && !PWRITE &&
                   PADDR == ADDR_STATUS;
    property p_fail_ones;
        TRIBUTARY_SERVER_FAIL_OUT && $past(TRIBUTARY_SERVER_FAIL_OUT)
            |-> TRIBUTARY_DATA_OUT;
    endproperty
    a_fail_ones: assert property (p_fail_ones)
        else $error("data not all ones during server fail");
    property p_mfp_off;
        off && $past(off) && $past(off, 2) |-> !MULTIFRAME_PRESENT_OUT;
    endproperty
    a_mfp_off: assert property (p_mfp_off)
        else $error("multiframe present while setting off");
    property p_inact_ones;
        !act && $past(!act) && $past(!act, 2) |-> TRIBUTARY_DATA_OUT;
    endproperty
    a_inact_ones: assert property (p_inact_ones)
        else $error("data not all ones while inactive");
    property p_st_inact;
        rd_st && !act && $past(!act, 4) |-> PRDATA[2:0] == 3'h0;
    endproperty
    a_st_inact: assert property (p_st_inact)
        else $error("status reported while inactive");
    property p_ais_rep;
        rd_st && PRDATA[1] |-> PRDATA[5];
    endproperty
    a_ais_rep: assert property (p_ais_rep)
        else $error("all-ones report without defect");
    property p_lof_rep;
        rd_st && PRDATA[0] |-> PRDATA[4] && !PRDATA[5];
    endproperty
    a_lof_rep: assert property (p_lof_rep)
        else $error("frame loss report badly correlated");
    property p_fs_pulse;
        TRIBUTARY_FRAME_START_OUT |=> !TRIBUTARY_FRAME_START_OUT[*8];
    endproperty
    a_fs_pulse: assert property (p_fs_pulse)
        else $error("frame start not a lone pulse");
    property p_mfs_frame;
        TRIBUTARY_MULTIFRAME_START_OUT |-> TRIBUTARY_FRAME_START_OUT;
    endproperty
    a_mfs_frame: assert property (p_mfs_frame)
        else $error("multiframe start off a frame start");
    property p_clk_even;
        $rose(TRIBUTARY_CLOCK_OUT) |-> TRIBUTARY_CLOCK_OUT[*8]
            ##[2:3] !TRIBUTARY_CLOCK_OUT;
    endproperty
    a_clk_even: assert property (p_clk_even)
        else $error("smoothed clock high time wrong");
    property p_rdy;
        PSEL && !PENABLE && !PREADY |=> PREADY ##1 !PREADY;
    endproperty
    a_rdy: assert property (p_rdy)
        else $error("ready not one cycle after setup");
    property p_err;
        PSEL && !PENABLE && !PREADY && PADDR != ADDR_CTRL &&
            PADDR != ADDR_STATUS |=> PSLVERR && (PWRITE || PRDATA == 32'h0);
    endproperty
    a_err: assert property (p_err)
        else $error("unmapped access not refused");
endmodule // tdfa_sink_props
bind tdfa_sink tdfa_sink_props u_props (.REF_CLK, .NRST,
    .TRIBUTARY_DATA_OUT, .TRIBUTARY_CLOCK_OUT, .TRIBUTARY_SERVER_FAIL_OUT,
    .TRIBUTARY_FRAME_START_OUT, .TRIBUTARY_MULTIFRAME_START_OUT,
    .MULTIFRAME_PRESENT_OUT, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PRDATA, .PREADY, .PSLVERR);
`default_nettype wire

// ===== test/tdfa_mux_partner.sv
// Purpose: Multiplex frame source feeding the sink
// Assumes: Link clock 200 ns, runs continuously, data moves on its fall
// Notes:   Stuffing alternates frame by frame; ones_mode sends all ones in the tributary slot
`timescale 1ns/1ps
`default_nettype none
module tdfa_mux_partner
    import tdfa_pkg::*;
#(
    parameter int unsigned SLOT = 1
) (
    // Pattern select
    input  wire logic ones_mode,
    // Payload towards the sink
    output logic      pay_clk,
    output logic      pay_data,
    output logic      pay_fs
);
    int b;
    int fr;
    int p;
    // Tributary bit stream with frame words
    function automatic logic trib(input int pos);
        if (ones_mode || pos % 256 == 0 || pos == 257)
            return 1'b1;
        if (pos >= 1 && pos <= 7)
            return FAS_WORD[7-pos];
        return pos[0];
    endfunction
    // Next multiplex bit, slot layout
    task automatic next_bit;
        int       s;
        int       q;
        logic [2:0] c;
        s = b / 212;
        q = b % 212;
        c = fr[0] ? 3'b011 : 3'b010;
        pay_fs = (b == 0);
        if (q % 4 != SLOT - 1)
            pay_data = q[1];
        else if (s == 0 && q < 12)
            pay_data = 1'b1;
        else if (s > 0 && q < 4)
            pay_data = c[s-1];
        else if (s == 3 && q < 8 && fr[0])
            pay_data = 1'b0;
        else begin
            pay_data = trib(p);
            p = (p + 1) % 512;
        end
        b = (b + 1) % 848;
        if (b == 0)
            fr++;
    endtask
    // Sole driver of the access point
    initial begin
        pay_clk = 1'b0;
        b = 0;
        fr = 0;
        p = 0;
        next_bit();
        #37;
        forever begin
            #100 pay_clk = 1'b1;
            #100 pay_clk = 1'b0;
            next_bit();
        end
    end
endmodule // tdfa_mux_partner
`default_nettype wire

// ===== test/tb_top.sv
// Purpose: Self-checking bench for the tributary demap sink
// Assumes: Payload runs slower than the tributary, store starves
// Notes:   Register map, reports and all-ones paths against a model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import tdfa_pkg::*;
    logic        ref_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tsf = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        ones = 1'b0, err, pready, pslverr, pck, pd, pfs;
    logic        dout, ck, sf, fs, mfs, mfp;
    int          mismatches = 0, n_tests = 0, seed = 84985, i, n;
    int          act, rep, mode, tm, lof, ais;
    always #12.5 ref_clk = ~ref_clk;
    tdfa_sink #(.SLOT(2)) uut (.REF_CLK(ref_clk), .NRST(nrst),
        .MULTIPLEX_PAYLOAD_DATA_IN(pd), .MULTIPLEX_PAYLOAD_CLOCK_IN(pck),
        .MULTIPLEX_FRAME_START_IN(pfs), .INCOMING_TRAIL_FAIL(tsf),
        .TRIBUTARY_DATA_OUT(dout), .TRIBUTARY_CLOCK_OUT(ck),
        .TRIBUTARY_SERVER_FAIL_OUT(sf), .TRIBUTARY_FRAME_START_OUT(fs),
        .TRIBUTARY_MULTIFRAME_START_OUT(mfs), .MULTIFRAME_PRESENT_OUT(mfp),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr));
    tdfa_mux_partner #(.SLOT(2)) u_mux (.ones_mode(ones), .pay_clk(pck),
        .pay_data(pd), .pay_fs(pfs));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer, answer taken at the edge that sees pready high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1 && k < 20) begin
            @(posedge ref_clk);
            k++;
        end
        rd = prdata;
        err = pslverr;
        if (k == 20) chk(32'h0, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    // Model of the status word, raw bits hidden while inactive
    function automatic logic [5:0] exp_st();
        return {act && ais, act && lof, 2'b00,
                act && ais && !tm && rep, act && lof && !ais && !tm};
    endfunction
    // Random control combination, mode walks all four codes
    task trial(input int k, input int ra);
        act = ra ? ($random(seed) & 1) : 1;
        rep = $random(seed) & 1;
        tm = $random(seed) & 1;
        mode = k % 4;
        apb(1'b1, ADDR_CTRL, 32'(act | rep << 1 | mode << 2));
        tsf <= 1'(tm);
        repeat (8) @(posedge ref_clk);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, 32'(act | rep << 1 | mode << 2));
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(rd[5:0] & (act ? 6'h3f : 6'h0f), exp_st());
        chk(sf, 1'b1);
        chk(mfp, 1'b0);
        if (act == 0) chk(dout, 1'b1);
    endtask
    task print_verdict;
        if (mismatches == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Hang guard
    initial begin
        #2000000;
        chk(32'h0, 32'h1);
        print_verdict();
    end
    // Main sequence
    initial begin
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        @(negedge ref_clk);
        @(negedge ref_clk);
        chk({dout, sf, ck, fs, mfs, mfp}, 6'b110000);
        @(posedge ref_clk);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b1, 8'h0c, 32'hffffffff);
        chk(err, 1'b1);
        apb(1'b1, ADDR_STATUS, 32'hffffffff);
        chk(err, 1'b0);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, 32'h1);
        lof = 1;
        ais = 0;
        repeat (2000) @(posedge ref_clk);
        for (i = 0; i < 12; i++) trial(i, 1);
        ones <= 1'b1;
        apb(1'b1, ADDR_CTRL, 32'h3);
        tsf <= 1'b0;
        n = 0;
        do begin
            repeat (20) @(posedge ref_clk);
            apb(1'b0, ADDR_STATUS, 32'h0);
            n++;
        end while (rd[5] !== 1'b1 && n < 2500);
        chk(rd[5], 1'b1);
        ais = 1;
        for (i = 0; i < 8; i++) trial(i, 0);
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
